// >>> design/ibt_pkg.sv
package ibt_pkg;
   localparam int IBT_MC_DIV = 6;
   localparam logic [2:0] IBT_MC_LAST = 3'h5;
   localparam int IBT_TMR_W = 10;
   localparam logic [9:0] IBT_TMR_MIN = 10'h008;
   localparam logic [9:0] IBT_TMR_MAX = 10'h3FF;
   localparam logic [1:0] IBT_SEL_7 = 2'h2;
   localparam logic [1:0] IBT_SEL_6 = 2'h1;
   localparam logic [1:0] IBT_SEL_5 = 2'h0;
   localparam logic [1:0] IBT_SEL_4 = 2'h3;
   localparam logic [3:0] IBT_CNT_7 = 4'h7;
   localparam logic [3:0] IBT_CNT_6 = 4'h6;
   localparam logic [3:0] IBT_CNT_5 = 4'h5;
   localparam logic [3:0] IBT_CNT_4 = 4'h4;
   // APB map
   localparam logic [11:0] IBT_A_CFG = 12'h000;
   localparam logic [11:0] IBT_A_CTL = 12'h004;
   localparam logic [11:0] IBT_A_STS = 12'h008;
   localparam logic [11:0] IBT_A_MSK = 12'h00C;
   localparam logic [11:0] IBT_A_TMR = 12'h010;
   // CFG fields
   localparam int IBT_CFG_MTS_LO = 0;
   localparam int IBT_CFG_MTS_HI = 1;
   localparam int IBT_CFG_RUN = 2;
   localparam int IBT_CFG_TEN = 3;
   localparam int IBT_CFG_REQ = 4;
   localparam logic [4:0] IBT_CFG_RST = 5'h00;
   // CTL write fields
   localparam int IBT_CTL_TXBIT = 0;
   localparam int IBT_CTL_WDAT = 1;
   localparam int IBT_CTL_CDR = 2;
   localparam int IBT_CTL_CXA = 3;
   // Status event bits
   localparam int IBT_EV_READY = 0;
   localparam int IBT_EV_HANG = 1;
   localparam int IBT_EV_W = 2;
endpackage

// >>> design/ibt_min_timer.sv
`timescale 1ns/1ps
module ibt_min_timer
   import ibt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mc_tick,
   input wire logic reload,
   input wire logic clear,
   input wire logic full_run,
   input wire logic low_run,
   input wire logic [1:0] sel,
   output logic min_done,
   output logic overflow,
   output logic [9:0] count
);
   logic [3:0] min_cnt;
   logic [9:0] count_r;

   always_comb
   begin
      case (sel)
         IBT_SEL_7: min_cnt = IBT_CNT_7;
         IBT_SEL_6: min_cnt = IBT_CNT_6;
         IBT_SEL_5: min_cnt = IBT_CNT_5;
         IBT_SEL_4: min_cnt = IBT_CNT_4;
         default: min_cnt = IBT_CNT_5;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= 10'h000;
      else if (clear)
         count_r <= 10'h000;
      else if (reload)
         count_r <= IBT_TMR_MIN - {6'h00, min_cnt};
      else if (mc_tick && full_run)
         count_r <= count_r + 10'h001;
      else if (mc_tick && low_run && count_r[2:0] != 3'h0 && count_r < IBT_TMR_MIN)
         count_r[2:0] <= count_r[2:0] + 3'h1;
   end

   // Low bits wrap to zero at eight; treat any count of eight or more, or a wrap in low run, as done
   assign min_done = (count_r >= IBT_TMR_MIN) || (low_run && !full_run && count_r[2:0] == 3'h0);
   assign overflow = full_run && mc_tick && (count_r == IBT_TMR_MAX);
   assign count = count_r;
endmodule

// >>> design/ibt_core.sv
`timescale 1ns/1ps
module ibt_core
   import ibt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);
   ////////////////////////////////////////////////////////////
   logic [2:0] scl_s, sda_s;
   logic [2:0] mc_cnt_r;
   logic mc_tick;
   logic [4:0] cfg_r;
   logic [IBT_EV_W-1:0] sts_r, msk_r;
   logic data_ready_flag_r, transmit_data_bit_r, tx_active_r, sda_low_r;
   logic scl_low_r, irq_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic scl_rise, scl_fall, sda_rise, sda_fall, start_c, stop_c;
   logic mode_en, run, in_frame_r;
   logic min_done, overflow;
   logic [9:0] tcount;
   logic wr_acc, rd_acc, acc, mapped;

   ////////////////////////////////////////////////////////////
   // Pin synchronisers; stage 0 read only by stage 1
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end
      else
      begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
      end
   end

   assign scl_rise = scl_s[1] && !scl_s[2];
   assign scl_fall = !scl_s[1] && scl_s[2];
   assign sda_rise = sda_s[1] && !sda_s[2];
   assign sda_fall = !sda_s[1] && sda_s[2];
   assign start_c = sda_fall && scl_s[1] && scl_s[2];
   assign stop_c = sda_rise && scl_s[1] && scl_s[2];

   ////////////////////////////////////////////////////////////
   // Machine cycle: six clocks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mc_cnt_r <= 3'h0;
      else if (mc_cnt_r == IBT_MC_LAST)
         mc_cnt_r <= 3'h0;
      else
         mc_cnt_r <= mc_cnt_r + 3'h1;
   end
   assign mc_tick = (mc_cnt_r == IBT_MC_LAST);

   ////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign acc = psel && penable;
   assign wr_acc = acc && pwrite;
   assign rd_acc = acc && !pwrite;
   assign mapped = (paddr == IBT_A_CFG) || (paddr == IBT_A_CTL) || (paddr == IBT_A_STS) ||
                   (paddr == IBT_A_MSK) || (paddr == IBT_A_TMR);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_r <= IBT_CFG_RST;
      else if (wr_acc && paddr == IBT_A_CFG)
         cfg_r <= pwdata[4:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         msk_r <= '0;
      else if (wr_acc && paddr == IBT_A_MSK)
         msk_r <= pwdata[IBT_EV_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !mapped;
         prdata_r <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               IBT_A_CFG: prdata_r <= {27'h0, cfg_r};
               IBT_A_CTL: prdata_r <= {26'h0, scl_low_r, sda_low_r, tx_active_r, data_ready_flag_r,
                                       transmit_data_bit_r, scl_s[2]};
               IBT_A_STS: prdata_r <= {30'h0, sts_r};
               IBT_A_MSK: prdata_r <= {30'h0, msk_r};
               IBT_A_TMR: prdata_r <= {22'h0, tcount};
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end
   // Answer held through the access phase
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   ////////////////////////////////////////////////////////////
   // Mode and timer control
   assign mode_en = cfg_r[IBT_CFG_TEN] || cfg_r[IBT_CFG_REQ];
   assign run = cfg_r[IBT_CFG_RUN];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_frame_r <= 1'b0;
      else if (overflow || !mode_en || stop_c)
         in_frame_r <= 1'b0;
      else if (start_c)
         in_frame_r <= 1'b1;
   end

   ibt_min_timer u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .mc_tick(mc_tick),
      .reload(mode_en && (scl_rise || scl_fall)),
      .clear(!mode_en || start_c || stop_c),
      .full_run(mode_en && run && in_frame_r),
      .low_run(mode_en && !run),
      .sel({cfg_r[IBT_CFG_MTS_HI], cfg_r[IBT_CFG_MTS_LO]}),
      .min_done(min_done),
      .overflow(overflow),
      .count(tcount)
   );

   ////////////////////////////////////////////////////////////
   // Data ready, transmit bit and transmit active
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         data_ready_flag_r <= 1'b0;
      else if (overflow || !mode_en)
         data_ready_flag_r <= 1'b0;
      else if (scl_rise)
         data_ready_flag_r <= 1'b1;
      else if (wr_acc && paddr == IBT_A_CTL && (pwdata[IBT_CTL_CDR] || pwdata[IBT_CTL_WDAT]))
         data_ready_flag_r <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         transmit_data_bit_r <= 1'b1;
      else if (wr_acc && paddr == IBT_A_CTL && pwdata[IBT_CTL_WDAT])
         transmit_data_bit_r <= pwdata[IBT_CTL_TXBIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_active_r <= 1'b0;
      else if (overflow || !mode_en)
         tx_active_r <= 1'b0;
      else if (wr_acc && paddr == IBT_A_CTL && pwdata[IBT_CTL_WDAT])
         tx_active_r <= 1'b1;
      else if (wr_acc && paddr == IBT_A_CTL && pwdata[IBT_CTL_CXA])
         tx_active_r <= 1'b0;
   end

   // Bit applied only in SCL low, as soon as sync stages 1 and 2 both see it low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sda_low_r <= 1'b0;
      else if (!tx_active_r)
         sda_low_r <= 1'b0;
      else if (!scl_s[2] && !scl_s[1])
         sda_low_r <= !transmit_data_bit_r;
   end

   // Stretch low phase until serviced and min low time met
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         scl_low_r <= 1'b0;
      else if (!mode_en || overflow)
         scl_low_r <= 1'b0;
      else if (scl_fall)
         scl_low_r <= 1'b1;
      else if (scl_low_r && !data_ready_flag_r && min_done)
         scl_low_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // Sticky events, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sts_r <= '0;
      else
      begin
         for (int i = 0; i < IBT_EV_W; i++)
         begin
            if ((i == IBT_EV_READY && scl_rise && mode_en) || (i == IBT_EV_HANG && overflow))
               sts_r[i] <= 1'b1;
            else if (wr_acc && paddr == IBT_A_STS && pwdata[i])
               sts_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(sts_r & msk_r);
   end

   assign irq = irq_r;
   assign scl_out = 1'b0;
   assign scl_oe = scl_low_r;
   assign sda_out = 1'b0;
   assign sda_oe = sda_low_r;
endmodule

// >>> test/ibt_core_sva.sv
`timescale 1ns/1ps
module ibt_core_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq
);
   logic scl_d_r;
   logic [5:0] lo_cnt_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since SCL last fell, saturating
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_d_r <= 1'b1;
         lo_cnt_r <= 6'h3F;
      end
      else
      begin
         scl_d_r <= scl_in;
         if (scl_d_r && !scl_in)
            lo_cnt_r <= 6'h00;
         else if (lo_cnt_r != 6'h3F)
            lo_cnt_r <= lo_cnt_r + 6'h01;
      end
   end
   ////////////////////////////////////////
   open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("pin driven high");
   sda_at_low_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2) || !$past(scl_in, 3))
      else $error("sda changed while scl high");
   stretch_low_a: assert property ($rose(scl_oe) |-> !$past(scl_in, 2) || !$past(scl_in, 3))
      else $error("stretch began while scl high");
   min_low_a: assert property ($fell(scl_oe) |-> lo_cnt_r >= 6'd18)
      else $error("scl low phase too short");
   quiet_reset_a: assert property (disable iff (1'b0) !presetn |-> !scl_oe && !sda_oe && !irq)
      else $error("outputs active in reset");
   ready_next_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   slverr_pair_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   refused_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
endmodule
bind ibt_core ibt_core_sva i_ibt_core_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// >>> test/ibt_bus_peer.sv
`timescale 1ns/1ps
module ibt_bus_peer (
   input wire logic scl_w,
   output logic scl_low,
   output logic sda_low
);
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   ////////////////////////////////////////
   task automatic start_cond();
      // Keep pin changes clear of the sampling edge
      #25;
      sda_low = 1'b1;
      #400;
      scl_low = 1'b1;
      #400;
   endtask
   // One bit; waits while the target stretches SCL
   task automatic bit_cycle(input logic b, input int hi_ns);
      int n;
      n = 0;
      #25;
      sda_low = !b;
      #400;
      scl_low = 1'b0;
      while (scl_w !== 1'b1 && n < 20000)
      begin
         #100;
         n++;
      end
      #(hi_ns);
      scl_low = 1'b1;
      #400;
   endtask
endmodule

// >>> test/ibt_core_bench.sv
`timescale 1ns/1ps
module ibt_core_bench;
   import ibt_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, p_scl, p_sda, slv;
   wire scl_w = ~(scl_oe | p_scl);
   wire sda_w = ~(sda_oe | p_sda);
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   int t0;
   always #50 pclk = ~pclk;
   ibt_core i_ibt_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
   ibt_bus_peer i_ibt_bus_peer (.scl_w(scl_w), .scl_low(p_scl), .sda_low(p_sda));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 50);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic end_of_test();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   ////////////////////////////////////////
   initial
   begin
      #5 presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(IBT_A_CFG, 32'h0);
      rd(IBT_A_TMR, 32'h0);
      rd(12'h020, 32'h0);
      chk(slv, 1'b1);
      // Slowest select, clock is beyond every entry
      apb(1'b1, IBT_A_CFG, 32'h0E);
      i_ibt_bus_peer.start_cond();
      i_ibt_bus_peer.bit_cycle(1'b1, 400);
      repeat (10) @(posedge pclk);
      rd(IBT_A_CTL, 32'h26);
      rd(IBT_A_STS, 32'h1);
      chk(irq, 1'b0);
      apb(1'b1, IBT_A_MSK, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, IBT_A_CTL, 32'h2);
      repeat (60) @(posedge pclk);
      rd(IBT_A_CTL, 32'h18);
      fork
         i_ibt_bus_peer.bit_cycle(1'b1, 3000);
         begin
            repeat (15) @(posedge pclk);
            apb(1'b1, IBT_A_CTL, 32'h3);
            repeat (4) @(posedge pclk);
            rd(IBT_A_CTL, 32'h1B);
         end
      join
      repeat (60) @(posedge pclk);
      rd(IBT_A_CTL, 32'h0A);
      apb(1'b1, IBT_A_STS, 32'h1);
      rd(IBT_A_STS, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      // Left unanswered until the hang timer fires
      i_ibt_bus_peer.bit_cycle(1'b1, 400);
      t0 = cyc;
      apb(1'b1, IBT_A_MSK, 32'h2);
      do
         apb(1'b0, IBT_A_STS, 32'h0);
      while (q[1] !== 1'b1 && cyc - t0 < 7000);
      chk(cyc - t0 >= 6000 && cyc - t0 <= 6200, 1'b1);
      rd(IBT_A_CTL, 32'h02);
      chk(irq, 1'b1);
      apb(1'b1, IBT_A_MSK, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, IBT_A_STS, 32'h3);
      rd(IBT_A_STS, 32'h0);
      // Silence the interface; timer and state fall back to idle
      apb(1'b1, IBT_A_CFG, 32'h0);
      repeat (2) @(posedge pclk);
      rd(IBT_A_TMR, 32'h0);
      rd(IBT_A_CTL, 32'h02);
      end_of_test();
   end
endmodule
